// ===== logic/mmd_decoder.sv
// Top-level memory map decoder for the 8051 core's code, external-data and internal spaces.
`timescale 1ns/1ps
//
// Behaviour
// - Unified RAM serves fetches, code reads and external-data reads and writes at 0x0000 to 0x11FF.
// - ROM executes only; data reads of ROM return an undefined byte. The decoder has no ROM store, so ROM fetches return it too.
// - Non-volatile stores are not memory mapped except the read-only array window.
// - Internal data RAM holds 256 bytes at 0x00 to 0xFF.
// - Lower 128 internal bytes read the same by direct or indirect mode.
// - Bytes to 0x1F form four register banks chosen by status bits 3 and 4.
// - Indirect pointer comes from working register 0 or 1 of active bank.
// - Bytes 0x20-0x2F are 128 bits, bit address 8*(byte-0x20)+position.
// - Bit operand makes a bit access, byte operand a byte access.
// - Above 0x7F direct goes to special registers, indirect to upper RAM.
// - Push writes pointer plus one, then increments the stack pointer.
// - Reset loads stack pointer with 0x07.
// - Stack reaches all 256 internal bytes through indirect access.
// - Special registers at addresses ending 0x0 or 0x8 are bit addressable.
// - Mapped hardware registers answer external-data moves only, like memory.
// - Multi-byte mapped registers are most significant byte first.
// - Array contents appear read-only at 0x4040 to 0x404F.
// - Writes never change the array contents.
// - Unchanged bits cause no wear on reprogramming.
// - A 256-byte hardware register window sits in external-data space.
//
module mmd_decoder #(
   parameter int RAM_WORDS = mmd_pkg::RAM_WORDS
) (
   // Clock and reset.
   input  wire logic         sys_clk,
   input  wire logic         rst_b,
   // Code and external-data port; fetch, code read, external move read/write.
   input  wire logic         fetch_en,
   input  wire logic         code_read_en,
   input  wire logic         xdata_rd_en,
   input  wire logic         xdata_wr_en,
   input  wire logic [15:0]  code_addr,
   input  wire logic [7:0]   code_wdata,
   output      logic [7:0]   code_rdata,
   output      logic         xdata_mapped_registers_sel,
   // Array contents from the non-volatile store.
   input  wire logic [127:0] otp_array_data,
   // Internal data port; direct or indirect, byte or bit.
   input  wire logic         int_rd_en,
   input  wire logic         int_wr_en,
   input  wire logic         int_indirect,
   input  wire logic         int_use_r1,
   input  wire logic         int_bit_op,
   input  wire logic [7:0]   int_addr,
   input  wire logic [7:0]   int_wdata,
   input  wire logic         int_wbit,
   input  wire logic         push_en,
   input  wire logic         pop_en,
   output      logic [7:0]   int_rdata,
   output      logic         int_rbit,
   output      logic         sfr_sel,
   output      logic [7:0]   sfr_addr,
   // Status visible to the core.
   output      logic [7:0]   stack_top_pointer,
   output      logic [7:0]   program_status_word
);
   // Region codes of the code/external-data map.
   // One-hot, so a wrong decode shows up as a single stray bit.
   typedef enum logic [4:0] {
      MMD_RGN_RAM  = 5'b00001,
      MMD_RGN_XDATA_MAPPED_REGISTERS = 5'b00010,
      MMD_RGN_WIN  = 5'b00100,
      MMD_RGN_ROM  = 5'b01000,
      MMD_RGN_NONE = 5'b10000
   } mmd_rgn_type;

   typedef struct packed {
      logic [7:0] stack_top_pointer;
      logic [7:0] program_status_word;
      logic [7:0] code_rdata;
      logic [7:0] int_rdata;
      logic       int_rbit;
      // Copy of the 32 bank bytes, so a pointer is read in the same cycle as its target.
      logic [31:0][7:0] bank_copy;
   } mmd_state_type;

   mmd_state_type st_r;
   mmd_state_type st_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // True when the address lies in an inclusive range.
   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // Bit operands arrive as bit addresses, never as byte addresses.
   // The low half of the bit space lands in the bit area of internal RAM.
   // The high half lands in the special register whose address is the bit address
   // with its three low bits cleared, which is why only registers ending in 0 or 8
   // can be reached bit by bit.
   // Maps a bit address to its byte, for the bit area or a bit-addressable special register.
   function automatic logic [7:0] bit_byte(input logic [7:0] b);
      if (b <= mmd_pkg::LOWER_LAST) begin
         bit_byte = mmd_pkg::BITAREA_BASE + {4'h0, b[6:3]};
      end else begin
         bit_byte = {b[7:3], 3'b000};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Code and external-data decode.
   //
   // Fetches, code reads and external moves share one address bus.
   // Each address falls in exactly one region, and the region decides the answer.
   // The array window sits inside the register block, so it is tested first.
   // Registers of the block itself live outside this decoder; only their select is given.
   // The read-only store and the one-time store have no path here at all,
   // apart from the window, so no instruction can change them.

   logic        ram_hit;
   logic        rom_hit;
   logic        otp_hit;
   logic        xdata_mapped_registers_hit;
   logic [3:0]  otp_idx;
   logic [7:0]  otp_byte;
   mmd_rgn_type code_rgn;
   mmd_xbus_if  xbus ();

   assign ram_hit  = in_range(code_addr, mmd_pkg::RAM_BASE, mmd_pkg::RAM_LAST);
   assign xdata_mapped_registers_hit = in_range(code_addr, mmd_pkg::XDATA_MAPPED_REGISTERS_BASE, mmd_pkg::XDATA_MAPPED_REGISTERS_LAST);
   assign rom_hit  = in_range(code_addr, mmd_pkg::ROM_BASE, mmd_pkg::ROM_LAST);
   assign otp_hit  = in_range(code_addr, mmd_pkg::OTPW_BASE, mmd_pkg::OTPW_LAST);
   assign otp_idx  = code_addr[3:0];

   // One region per address; the window wins over the register block around it.
   always_comb begin
      if (otp_hit) begin
         code_rgn = MMD_RGN_WIN;
      end else if (xdata_mapped_registers_hit) begin
         code_rgn = MMD_RGN_XDATA_MAPPED_REGISTERS;
      end else if (ram_hit) begin
         code_rgn = MMD_RGN_RAM;
      end else if (rom_hit) begin
         code_rgn = MMD_RGN_ROM;
      end else begin
         code_rgn = MMD_RGN_NONE;
      end
   end

   // Byte 0 is the most significant byte, held at the lowest address.
   assign otp_byte = otp_array_data[(8'd127 - {otp_idx, 3'b000}) -: 8];

   // Mapped registers only answer external moves; fetches and code reads never see them.
   assign xdata_mapped_registers_sel = xdata_mapped_registers_hit && (xdata_rd_en || xdata_wr_en);

   // The store is written only on an external move that hits it.
   // A fetch or code read never writes, so code cannot patch itself by accident.
   // The array window has no write path at all, so a write there only reaches the register block.
   assign xbus.we    = xdata_wr_en && ram_hit;
   assign xbus.addr  = code_addr[12:0];
   assign xbus.wdata = code_wdata;

   mmd_unified_ram #(
      .WORDS (RAM_WORDS)
   ) u_ram (
      .sys_clk (sys_clk),
      .bus     (xbus.slave)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Internal data decode.
   //
   // Direct, indirect, bit and stack accesses all resolve to one effective address.
   // Indirect and stack accesses always go to RAM, even above 0x7F.
   // Direct accesses above 0x7F go to the special registers instead.
   // The pointer for indirect access is read from a flip-flop copy of the banks,
   // because the RAM has only one read port and it is busy with the target.

   logic [7:0]  bank_base;
   logic [7:0]  ptr_addr;
   logic [7:0]  ptr_value;
   logic [7:0]  eff_addr;
   logic        upper_direct;
   logic        id_we;
   logic [7:0]  id_addr;
   logic [7:0]  id_wdata;
   logic [7:0]  id_rdata;
   logic [7:0]  sfr_byte;
   logic [7:0]  target_byte;
   logic [7:0]  old_byte;
   logic [2:0]  bit_pos;

   // Active bank comes from the two bank-select bits of the status word.
   assign bank_base = {3'b000,
                       st_r.program_status_word[mmd_pkg::BANK_HI_POS],
                       st_r.program_status_word[mmd_pkg::BANK_LO_POS], 3'b000};
   assign ptr_addr  = bank_base | {7'h00, int_use_r1};

   // A second RAM instance here would be written at the pointer address
   // instead of the real target, so the bank copy in the state is used.

   // Stack operations always go indirect so the whole 256 bytes are reachable.
   always_comb begin
      if (push_en) begin
         eff_addr = st_r.stack_top_pointer + 8'h01;
      end else if (pop_en) begin
         eff_addr = st_r.stack_top_pointer;
      end else if (int_indirect) begin
         eff_addr = ptr_value;
      end else if (int_bit_op) begin
         eff_addr = bit_byte(int_addr);
      end else begin
         eff_addr = int_addr;
      end
   end

   assign ptr_value    = st_r.bank_copy[ptr_addr[4:0]];
   assign bit_pos      = int_addr[2:0];
   // Direct access above the lower half selects special registers, never upper RAM.
   assign upper_direct = !int_indirect && !push_en && !pop_en && (eff_addr > mmd_pkg::LOWER_LAST);
   assign sfr_sel      = upper_direct && (int_rd_en || int_wr_en);
   assign sfr_addr     = eff_addr;
   assign id_addr      = eff_addr;
   assign old_byte     = upper_direct ? sfr_byte : id_rdata;

   // Bit writes are read-modify-write of the containing byte.
   always_comb begin
      target_byte = old_byte;
      if (int_bit_op) begin
         target_byte[bit_pos] = int_wbit;
      end else begin
         target_byte = int_wdata;
      end
   end

   assign id_we    = (int_wr_en || push_en) && !upper_direct;
   assign id_wdata = target_byte;

   mmd_idata u_idata (
      .sys_clk (sys_clk),
      .we      (id_we),
      .addr    (id_addr),
      .wdata   (id_wdata),
      .rdata   (id_rdata)
   );

   // The pointer and the status word are the only special registers kept here.
   // Unoccupied addresses read as the undefined byte and ignore writes,
   // which is the safest answer to software that should not touch them.
   // Only the special registers held here answer; other addresses read undefined.
   always_comb begin
      case (eff_addr)
         mmd_pkg::SFR_STACK_PTR: sfr_byte = st_r.stack_top_pointer;
         mmd_pkg::SFR_STATUS:    sfr_byte = st_r.program_status_word;
         default:                sfr_byte = mmd_pkg::UNDEF_BYTE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state.
   //
   // Read data is registered, so it appears one cycle after the request
   // and stands until the next read on the same port.
   // The stack pointer moves after the push has stored its byte,
   // so the byte lands at the old pointer plus one.

   always_comb begin
      st_nxt = st_r;
      // Code space read data: one region per address, undefined elsewhere.
      if (fetch_en || code_read_en || xdata_rd_en) begin
         case (code_rgn)
            MMD_RGN_RAM: begin
               st_nxt.code_rdata = xbus.rdata;
            end
            MMD_RGN_WIN: begin
               // Only an external move sees the window contents.
               st_nxt.code_rdata = xdata_rd_en ? otp_byte : mmd_pkg::UNDEF_BYTE;
            end
            MMD_RGN_ROM: begin
               st_nxt.code_rdata = mmd_pkg::UNDEF_BYTE;
            end
            default: begin
               st_nxt.code_rdata = mmd_pkg::UNDEF_BYTE;
            end
         endcase
      end
      // Keep the bank copy in step with every store below the bit area.
      if (id_we && (id_addr < mmd_pkg::BITAREA_BASE)) begin
         st_nxt.bank_copy[id_addr[4:0]] = id_wdata;
      end
      if (int_rd_en || pop_en) begin
         st_nxt.int_rdata = old_byte;
         st_nxt.int_rbit  = old_byte[bit_pos];
      end
      // Special register writes; a push increments the pointer after storing.
      if (int_wr_en && upper_direct) begin
         if (eff_addr == mmd_pkg::SFR_STACK_PTR) begin
            st_nxt.stack_top_pointer = target_byte;
         end else if (eff_addr == mmd_pkg::SFR_STATUS) begin
            st_nxt.program_status_word = target_byte;
         end
      end
      if (push_en) begin
         st_nxt.stack_top_pointer = st_r.stack_top_pointer + 8'h01;
      end else if (pop_en) begin
         st_nxt.stack_top_pointer = st_r.stack_top_pointer - 8'h01;
      end
   end

   // Registered state; the array is never stored here, so nothing can wear it.
   // The bank copy clears on reset while the RAM does not; pointers must be written before use.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r.stack_top_pointer   <= mmd_pkg::STACK_RESET;
         st_r.program_status_word <= mmd_pkg::STATUS_RESET;
         st_r.code_rdata          <= 8'h00;
         st_r.int_rdata           <= 8'h00;
         st_r.int_rbit            <= 1'b0;
         st_r.bank_copy           <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign code_rdata          = st_r.code_rdata;
   assign int_rdata           = st_r.int_rdata;
   assign int_rbit            = st_r.int_rbit;
   assign stack_top_pointer   = st_r.stack_top_pointer;
   assign program_status_word = st_r.program_status_word;
endmodule

// ===== logic/mmd_pkg.sv
// Package of address map, field positions and reset values for the memory map decoder.
package mmd_pkg;
   localparam logic [15:0] RAM_BASE      = 16'h0000;
   localparam logic [15:0] RAM_LAST      = 16'h11FF;
   localparam logic [15:0] XDATA_MAPPED_REGISTERS_BASE     = 16'h4000;
   localparam logic [15:0] XDATA_MAPPED_REGISTERS_LAST     = 16'h40FF;
   localparam logic [15:0] ROM_BASE      = 16'h8000;
   localparam logic [15:0] ROM_LAST      = 16'hAFFF;
   localparam logic [15:0] OTPW_BASE     = 16'h4040;
   localparam logic [15:0] OTPW_LAST     = 16'h404F;
   localparam logic [7:0]  SFR_STACK_PTR = 8'h81;
   localparam logic [7:0]  SFR_STATUS    = 8'hD0;
   localparam logic [7:0]  STACK_RESET   = 8'h07;
   localparam logic [7:0]  STATUS_RESET  = 8'h00;
   localparam logic [7:0]  LOWER_LAST    = 8'h7F;
   localparam logic [7:0]  BITAREA_BASE  = 8'h20;
   localparam int          BANK_LO_POS   = 3;
   localparam int          BANK_HI_POS   = 4;
   localparam logic [7:0]  UNDEF_BYTE    = 8'hFF;
   localparam int          RAM_WORDS     = 4608;
   localparam int          OTP_BYTES     = 16;
endpackage

// ===== logic/mmd_xbus_if.sv
// Interface carrying code/external-data requests from the decoder to its unified store.
`timescale 1ns/1ps
interface mmd_xbus_if;
   logic        we;
   logic [12:0] addr;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   modport master (output we, output addr, output wdata, input rdata);
   modport slave  (input we, input addr, input wdata, output rdata);
endinterface

// ===== logic/mmd_unified_ram.sv
// Unified code and external-data RAM shared by fetches and data moves.
`timescale 1ns/1ps
module mmd_unified_ram #(
   parameter int WORDS = mmd_pkg::RAM_WORDS
) (
   // Clock.
   input wire logic sys_clk,
   // Request port.
   mmd_xbus_if.slave bus
);
   logic [7:0] mem_r [WORDS];

   // Storage has no reset; contents come from the boot copy.
   always_ff @(posedge sys_clk) begin
      if (bus.we && (int'(bus.addr) < WORDS)) begin
         mem_r[bus.addr] <= bus.wdata;
      end
   end

   // Read is combinational so a fetch and a data read see the same byte.
   assign bus.rdata = (int'(bus.addr) < WORDS) ? mem_r[bus.addr] : mmd_pkg::UNDEF_BYTE;
endmodule

// ===== logic/mmd_idata.sv
// Internal data RAM of 256 bytes, lower and upper halves held in one array.
`timescale 1ns/1ps
module mmd_idata (
   // Clock.
   input wire logic       sys_clk,
   // Access port.
   input wire logic       we,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   output     logic [7:0] rdata
);
   logic [7:0] mem_r [256];

   // One array serves both modes, so direct and indirect see identical lower bytes.
   always_ff @(posedge sys_clk) begin
      if (we) begin
         mem_r[addr] <= wdata;
      end
   end

   assign rdata = mem_r[addr];
endmodule

// ===== tb/mmd_decoder_monitor.sv
// Port checker for the memory map decoder.
`timescale 1ns/1ps
module mmd_decoder_monitor #(
   parameter int RAM_WORDS = mmd_pkg::RAM_WORDS
) (
   // Clock and reset.
   input wire logic         sys_clk,
   input wire logic         rst_b,
   // Code and external-data side.
   input wire logic         code_read_en,
   input wire logic         xdata_rd_en,
   input wire logic         xdata_wr_en,
   input wire logic [15:0]  code_addr,
   input wire logic [7:0]   code_rdata,
   input wire logic         xdata_mapped_registers_sel,
   input wire logic [127:0] otp_array_data,
   // Internal side.
   input wire logic         int_rd_en,
   input wire logic         int_indirect,
   input wire logic         int_bit_op,
   input wire logic [7:0]   int_addr,
   input wire logic         push_en,
   input wire logic         pop_en,
   input wire logic         sfr_sel,
   input wire logic [7:0]   sfr_addr,
   input wire logic [7:0]   stack_top_pointer
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////
   // Window byte picked big-endian, and the holes between regions.
   logic [7:0] win_b;
   logic       hole;
   logic       drd;
   assign win_b = otp_array_data[7'h7F - {code_addr[3:0], 3'h0} -: 8];
   assign hole = (code_addr > 16'h11FF && code_addr < 16'h4000) || (code_addr > 16'h40FF && code_addr < 16'h8000)
                 || code_addr > 16'hAFFF;
   assign drd = code_read_en || xdata_rd_en;
   ////////////////////////////////////////
   property p_sp_reset; $rose(rst_b) |-> stack_top_pointer == 8'h07; endproperty
   a_sp_reset: assert property (p_sp_reset) else $error("pointer not 07 after reset");
   property p_push; push_en && !pop_en |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01; endproperty
   a_push: assert property (p_push) else $error("push did not step pointer");
   property p_xdata_mapped_registers; xdata_mapped_registers_sel == ((xdata_rd_en || xdata_wr_en) && code_addr[15:8] == 8'h40); endproperty
   a_xdata_mapped_registers: assert property (p_xdata_mapped_registers) else $error("register window select wrong");
   property p_rom; drd && code_addr[15:12] inside {4'h8, 4'h9, 4'hA} |=> code_rdata == 8'hFF; endproperty
   a_rom: assert property (p_rom) else $error("rom data read leaked");
   property p_win; xdata_rd_en && code_addr[15:4] == 12'h404 |=> code_rdata == $past(win_b); endproperty
   a_win: assert property (p_win) else $error("array window byte wrong");
   property p_hole; drd && hole |=> code_rdata == 8'hFF; endproperty
   a_hole: assert property (p_hole) else $error("unmapped read not undefined");
   property p_sfr; int_rd_en && !int_indirect && !int_bit_op && int_addr[7] |-> sfr_sel && sfr_addr == int_addr;
   endproperty
   a_sfr: assert property (p_sfr) else $error("direct upper access missed sfr");
   property p_ind; int_rd_en && int_indirect |-> !sfr_sel; endproperty
   a_ind: assert property (p_ind) else $error("indirect access hit sfr");
endmodule
bind mmd_decoder mmd_decoder_monitor #(.RAM_WORDS(RAM_WORDS)) mmd_decoder_monitor_inst (.sys_clk, .rst_b,
   .code_read_en, .xdata_rd_en, .xdata_wr_en, .code_addr, .code_rdata, .xdata_mapped_registers_sel, .otp_array_data, .int_rd_en,
   .int_indirect, .int_bit_op, .int_addr, .push_en, .pop_en, .sfr_sel, .sfr_addr, .stack_top_pointer);

// ===== tb/mmd_core_model.sv
// Behavioural model of the core that issues fetches and data accesses.
`timescale 1ns/1ps
module mmd_core_model (
   // Clock.
   input wire logic     sys_clk,
   // Code and external-data requests.
   output logic         fetch_en,
   output logic         code_read_en,
   output logic         xdata_rd_en,
   output logic         xdata_wr_en,
   output logic [15:0]  code_addr,
   output logic [7:0]   code_wdata,
   output logic [127:0] otp_array_data,
   // Internal requests.
   output logic         int_rd_en,
   output logic         int_wr_en,
   output logic         int_indirect,
   output logic         int_use_r1,
   output logic         int_bit_op,
   output logic [7:0]   int_addr,
   output logic [7:0]   int_wdata,
   output logic         int_wbit,
   output logic         push_en,
   output logic         pop_en
);
   // Everything idle at time zero.
   initial begin
      {fetch_en, code_read_en, xdata_rd_en, xdata_wr_en, code_addr, code_wdata, otp_array_data} = '0;
      {int_rd_en, int_wr_en, int_indirect, int_use_r1, int_bit_op, int_addr, int_wdata, int_wbit} = '0;
      {push_en, pop_en} = 2'h0;
   end
   // Requests replace each other at every falling edge, so they may run back to back.
   task automatic xreq(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      {fetch_en, code_read_en, xdata_rd_en, xdata_wr_en} = 4'h8 >> k; // One request kind per call; code and data share one store.
      code_addr = a;
      code_wdata = d;
      {int_rd_en, int_wr_en, push_en, pop_en} = 4'h0;
   endtask
   // Mode bits are indirect, second pointer, bit operand; only occupied special places are used.
   task automatic ireq(input logic [1:0] k, input logic [2:0] m, input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      {int_rd_en, int_wr_en, push_en, pop_en} = 4'h8 >> k;
      {int_indirect, int_use_r1, int_bit_op} = m;
      int_addr = a;
      int_wdata = d;
      int_wbit = d[0];
      {fetch_en, code_read_en, xdata_rd_en, xdata_wr_en} = 4'h0;
   endtask
   // Drops every request so nothing is left standing at the end of a run.
   task automatic idle();
      @(negedge sys_clk);
      {fetch_en, code_read_en, xdata_rd_en, xdata_wr_en} = 4'h0;
      {int_rd_en, int_wr_en, push_en, pop_en} = 4'h0;
   endtask
   // The array only ever changes as one whole image.
   task automatic load_image(input logic [127:0] img);
      @(negedge sys_clk);
      otp_array_data = img;
   endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the memory map decoder.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module testbench;
   logic         sys_clk, rst_b, fetch_en, code_read_en, xdata_rd_en, xdata_wr_en, xdata_mapped_registers_sel, int_rbit, sfr_sel;
   logic         int_rd_en, int_wr_en, int_indirect, int_use_r1, int_bit_op, int_wbit, push_en, pop_en;
   logic [15:0]  code_addr, a;
   logic [7:0]   code_wdata, code_rdata, int_addr, int_wdata, int_rdata, sfr_addr, d, xe;
   logic [7:0]   stack_top_pointer, program_status_word;
   logic [127:0] otp_array_data, img;
   logic [8:0]   ie;
   logic [7:0]   xq[$];
   logic [8:0]   iq[$];
   logic         xp = 1'b0;
   logic         ip = 1'b0;
   logic [31:0]  seed;
   logic [15:0]  bad [6] = '{16'h8000, 16'hAFFF, 16'h1200, 16'hB000, 16'hE000, 16'h7FFF};
   int           err_total, checks_done, i, k;
   mmd_core_model core_inst (.sys_clk, .fetch_en, .code_read_en, .xdata_rd_en, .xdata_wr_en, .code_addr,
      .code_wdata, .otp_array_data, .int_rd_en, .int_wr_en, .int_indirect, .int_use_r1, .int_bit_op, .int_addr,
      .int_wdata, .int_wbit, .push_en, .pop_en);
   mmd_decoder mmd_decoder_inst (.sys_clk, .rst_b, .fetch_en, .code_read_en, .xdata_rd_en, .xdata_wr_en,
      .code_addr, .code_wdata, .code_rdata, .xdata_mapped_registers_sel, .otp_array_data, .int_rd_en, .int_wr_en, .int_indirect,
      .int_use_r1, .int_bit_op, .int_addr, .int_wdata, .int_wbit, .push_en, .pop_en, .int_rdata, .int_rbit,
      .sfr_sel, .sfr_addr, .stack_top_pointer, .program_status_word);
   ////////////////////////////////////////
   // Clock at 100 MHz.
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Read requests note their expected answer at the moment they are issued.
   task automatic xr(input logic [1:0] kd, input logic [15:0] ad, input logic [7:0] e);
      core_inst.xreq(kd, ad, 8'h00);
      xq.push_back(e);
   endtask
   task automatic ir(input logic [1:0] kd, input logic [2:0] m, input logic [7:0] ad, input logic [8:0] e);
      core_inst.ireq(kd, m, ad, 8'h00);
      iq.push_back(e);
   endtask
   task automatic iw(input logic [2:0] m, input logic [7:0] ad, input logic [7:0] dt);
      core_inst.ireq(2'h1, m, ad, dt);
   endtask
   ////////////////////////////////////////
   // Answers are registered, so they are looked at half a cycle after the taking edge.
   always @(posedge sys_clk) begin
      xp <= fetch_en | code_read_en | xdata_rd_en;
      ip <= int_rd_en | pop_en;
   end
   always @(negedge sys_clk) begin
      if (xp === 1'b1) begin
         xe = xq.pop_front();
         `CHK("code_rdata", xe, code_rdata)
      end
      if (ip === 1'b1) begin
         ie = iq.pop_front();
         if (ie[8]) `CHK("int_rbit", ie[0], int_rbit) else `CHK("int_rdata", ie[7:0], int_rdata)
      end
   end
   task automatic close_out();
      if (err_total == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // The run needs about 150 cycles; a hang is cut off far beyond that.
   initial begin
      #50000;
      err_total++;
      close_out();
   end
   ////////////////////////////////////////
   initial begin
      rst_b = 1'b0;
      err_total = 0;
      checks_done = 0;
      seed = 32'h05E59AEE;
      repeat (8) @(negedge sys_clk);
      rst_b = 1'b1;
      `CHK("stack_top_pointer", 8'h07, stack_top_pointer)
      img = {rnd(), rnd(), rnd(), rnd()};
      core_inst.load_image(img);
      // Unified store: written by data move, read back by fetch, code read and data read.
      for (i = 0; i < 6; i++) begin
         a = (i == 0) ? 16'h11FF : 16'(rnd() % 32'h1200);
         d = 8'(rnd());
         core_inst.xreq(2'h3, a, d);
         for (k = 0; k < 3; k++) xr(2'(k), a, d);
      end
      // Rom and holes refuse writes and read as undefined.
      foreach (bad[j]) begin
         core_inst.xreq(2'h3, bad[j], 8'h5A);
         xr(2'h1, bad[j], 8'hFF);
         xr(2'h2, bad[j], 8'hFF);
      end
      // Array window: a write attempt, then two reads of every byte.
      for (i = 0; i < 16; i++) begin
         a = 16'h4040 + 16'(i);
         core_inst.xreq(2'h3, a, ~img[127 - 8 * i -: 8]);
         xr(2'h2, a, img[127 - 8 * i -: 8]);
         xr(2'h2, a, img[127 - 8 * i -: 8]);
      end
      xr(2'h0, 16'h4040, 8'hFF);
      // Each bank's second register points into upper RAM.
      for (i = 0; i < 4; i++) begin
         iw(3'h0, 8'hD0, 8'(i << 3));
         iw(3'h0, 8'(8 * i + 1), 8'(8'h90 + i));
         iw(3'h6, 8'h00, 8'(8'hA5 ^ i));
         ir(2'h0, 3'h6, 8'h00, 9'(8'hA5 ^ i));
      end
      for (i = 0; i < 4; i++) ir(2'h0, 3'h0, 8'(8 * i + 1), 9'(8'h90 + i));
      iw(3'h0, 8'hD0, 8'h00);
      iw(3'h0, 8'h00, 8'h81);
      iw(3'h4, 8'h00, 8'h5A);
      ir(2'h0, 3'h0, 8'h81, 9'h007);
      ir(2'h0, 3'h4, 8'h00, 9'h05A);
      iw(3'h0, 8'h00, 8'h30);
      iw(3'h0, 8'h30, 8'h3C);
      ir(2'h0, 3'h4, 8'h00, 9'h03C);
      // Bit area and a bit-addressable special register.
      iw(3'h0, 8'h22, 8'h00);
      iw(3'h1, 8'h13, 8'h01);
      ir(2'h0, 3'h0, 8'h22, 9'h008);
      ir(2'h0, 3'h1, 8'h13, 9'h101);
      ir(2'h0, 3'h1, 8'h12, 9'h100);
      iw(3'h1, 8'hD3, 8'h01);
      core_inst.ireq(2'h2, 3'h0, 8'h00, 8'h77);
      ir(2'h0, 3'h0, 8'h08, 9'h077);
      `CHK("program_status_word", 8'h08, program_status_word)
      `CHK("stack_top_pointer", 8'h08, stack_top_pointer)
      // Stack high in upper RAM.
      iw(3'h0, 8'h81, 8'hF0);
      core_inst.ireq(2'h2, 3'h0, 8'h00, 8'hE1);
      ir(2'h3, 3'h0, 8'h00, 9'h0E1);
      core_inst.xreq(2'h3, 16'h0000, 8'h3C);
      xr(2'h0, 16'h0000, 8'h3C);
      core_inst.idle();
      repeat (3) @(negedge sys_clk);
      `CHK("pending_reads", 0, xq.size() + iq.size())
      close_out();
   end
endmodule
